// ### core/gosc_pkg.sv
// Constants and carrier types for the global output and receive sync control.
// Assumes a single 250 MHz clock that also serves as the receive clock.
package gosc_pkg;
  // Register indices; the byte address is four times the index.
  localparam logic [5:0] IDX_COUNT_LOW = 6'h05;
  localparam logic [5:0] IDX_COUNT_HIGH = 6'h06;
  localparam logic [5:0] IDX_SYNC_SETUP = 6'h07;
  localparam logic [5:0] IDX_SOURCE_SELECT = 6'h08;
  localparam logic [5:0] IDX_DRIVE = 6'h23;
  localparam logic [5:0] IDX_ONESHOT = 6'h24;
  localparam logic [5:0] IDX_MASK_COMPOSITE = 6'h29;
  localparam logic [5:0] IDX_MASK_METERS_A = 6'h2a;
  localparam logic [5:0] IDX_MASK_METERS_B = 6'h2b;
  localparam logic [5:0] IDX_MASK_CIC = 6'h2c;
  // Field positions.
  localparam int POS_TIMER_SSEL = 8;
  localparam int POS_WIDTH = 0;
  localparam int POS_FIFO_SSEL = 12;
  localparam int POS_TX_ONESHOT = 15;
  localparam int POS_RX_ONESHOT = 7;
  localparam int POS_MASK_COMPOSITE = 12;
  localparam int POS_MASK_TX_METER = 4;
  localparam int POS_MASK_RX_MSB = 0;
  localparam int POS_MASK_RX_LSB = 8;
  localparam int POS_MASK_CIC = 0;
  localparam int SLICES = 4;
  localparam int POS_SLICE0 = 4;
  // Reset values.
  localparam logic [15:0] RST_COUNT = 16'hffff;
  localparam logic [10:0] RST_DRIVE = 11'h7ff;
  localparam logic [2:0] RST_FIFO_SSEL = 3'h6;
  localparam logic [2:0] RST_TIMER_SSEL = 3'h0;
  localparam logic [7:0] RST_WIDTH = 8'h00;
  // Sync source codes that this block fills in itself.
  localparam logic [2:0] SSEL_ONESHOT = 3'h1;
  localparam logic [2:0] SSEL_TIMER = 3'h2;

  typedef struct packed {
    logic port_a_oe_n;
    logic transmit_iq_flag_oe_n;
    logic tx_clock_oe_n;
    logic port_b_oe_n;
    logic port_c_oe_n;
    logic test_clock_oe_n;
    logic test_iq_flag_oe_n;
    logic test_sync_oe_n;
    logic port_d_oe_n;
    logic [SLICES-1:0] slice_sync_oe_n;
    logic tx_sync_out_oe_n;
    logic rx_sync_out_oe_n;
  } gosc_drive_t;

  typedef struct packed {
    logic [3:0] composite_meter;
    logic [11:0] tx_meter;
    logic [11:0] rx_meter;
    logic [11:0] tx_cic;
  } gosc_irq_src_t;
endpackage : gosc_pkg

// ### core/gosc_ctrl.sv
// Register bank for output drive enables, one-shot syncs, interrupt masks,
// the shared receive interval timer and receive sync source selection.
// Assumes an Avalon-MM master with byte addresses and a single clock.
//
// The implementer's own choice: the Avalon-MM interface to the registers.
module gosc_ctrl (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic reset_in,
  // Avalon-MM slave.
  input wire logic [7:0] address_in,
  input wire logic read_in,
  input wire logic write_in,
  input wire logic [3:0] byteenable_in,
  input wire logic [31:0] writedata_in,
  output logic [31:0] readdata_out,
  output logic waitrequest_out,
  // Receive sync sources, indexed by selection code.
  input wire logic [7:0] rx_sync_sources_in,
  // Interrupt source events.
  input wire gosc_pkg::gosc_irq_src_t irq_events_in,
  // Pin drive enables, low while the pins are driven.
  output gosc_pkg::gosc_drive_t drive_oe_n_out,
  // Sync pulses.
  output logic tx_oneshot_out,
  output logic rx_oneshot_out,
  output logic timer_sync_out,
  output logic fifo_pointer_reset_out,
  // Interrupt source indications.
  output gosc_pkg::gosc_irq_src_t irq_sources_out,
  output logic irq_request_out
);

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [15:0] count_low;
    logic [15:0] count_high;
    logic [2:0] timer_ssel;
    logic [7:0] width;
    logic [2:0] fifo_ssel;
    logic [10:0] drive;
    logic tx_shot_bit;
    logic rx_shot_bit;
    logic tx_pulse;
    logic rx_pulse;
    logic [3:0] mask_composite;
    logic [11:0] mask_tx_meter;
    logic [11:0] mask_rx_meter;
    logic [11:0] mask_cic;
    logic [31:0] timer;
    logic [8:0] pulse_left;
    logic timer_sync;
    logic fifo_sync;
    gosc_pkg::gosc_irq_src_t sources;
  } gosc_state_t;

  gosc_state_t state;
  gosc_state_t next_state;

  logic request;
  logic take;
  logic word_ok;
  logic [5:0] index;
  logic [15:0] wdata;
  logic [15:0] rword;
  logic [7:0] sources;
  logic restart;
  logic reach;
  gosc_pkg::gosc_irq_src_t masks;

  assign request = read_in | write_in;
  // One wait state gives the read data a full cycle to settle.
  assign waitrequest_out = request & ~state.ack;
  assign take = request & state.ack;
  assign word_ok = address_in[1:0] == 2'b00;
  assign index = address_in[7:2];

  // Only the low half of the word holds register bits.
  always_comb begin
    wdata = rword;
    if (byteenable_in[0]) begin
      wdata[7:0] = writedata_in[7:0];
    end
    if (byteenable_in[1]) begin
      wdata[15:8] = writedata_in[15:8];
    end
  end

  always_comb begin
    rword = 16'h0000;
    if (word_ok) begin
      unique case (index)
        gosc_pkg::IDX_COUNT_LOW: begin
          rword = state.count_low;
        end
        gosc_pkg::IDX_COUNT_HIGH: begin
          rword = state.count_high;
        end
        gosc_pkg::IDX_SYNC_SETUP: begin
          rword[gosc_pkg::POS_TIMER_SSEL +: 3] = state.timer_ssel;
          rword[gosc_pkg::POS_WIDTH +: 8] = state.width;
        end
        gosc_pkg::IDX_SOURCE_SELECT: begin
          rword[gosc_pkg::POS_FIFO_SSEL +: 3] = state.fifo_ssel;
        end
        gosc_pkg::IDX_DRIVE: begin
          rword[10:0] = state.drive;
        end
        gosc_pkg::IDX_ONESHOT: begin
          rword[gosc_pkg::POS_TX_ONESHOT] = state.tx_shot_bit;
          rword[gosc_pkg::POS_RX_ONESHOT] = state.rx_shot_bit;
        end
        gosc_pkg::IDX_MASK_COMPOSITE: begin
          rword[gosc_pkg::POS_MASK_COMPOSITE +: 4] = state.mask_composite;
        end
        gosc_pkg::IDX_MASK_METERS_A: begin
          rword[gosc_pkg::POS_MASK_TX_METER +: 12] = state.mask_tx_meter;
          rword[gosc_pkg::POS_MASK_RX_MSB +: 4] = state.mask_rx_meter[11:8];
        end
        gosc_pkg::IDX_MASK_METERS_B: begin
          rword[gosc_pkg::POS_MASK_RX_LSB +: 8] = state.mask_rx_meter[7:0];
        end
        gosc_pkg::IDX_MASK_CIC: begin
          rword[gosc_pkg::POS_MASK_CIC +: 12] = state.mask_cic;
        end
        default: begin
          rword = 16'h0000;
        end
      endcase
    end
  end

  // The one-shot and timer codes are produced here; other codes come in.
  always_comb begin
    sources = rx_sync_sources_in;
    sources[gosc_pkg::SSEL_ONESHOT] = state.rx_pulse;
    sources[gosc_pkg::SSEL_TIMER] = state.timer_sync;
  end

  // Selecting the timer as its own restart would hold it at zero for as long as its sync pulse stays high.
  assign restart = sources[state.timer_ssel]
    & (state.timer_ssel != gosc_pkg::SSEL_TIMER);
  assign reach = state.timer == {state.count_high, state.count_low};

  assign masks = '{
    composite_meter: state.mask_composite,
    tx_meter: state.mask_tx_meter,
    rx_meter: state.mask_rx_meter,
    tx_cic: state.mask_cic
  };

  always_comb begin
    next_state = state;
    next_state.ack = request & ~state.ack;
    if (request & ~state.ack) begin
      next_state.rdata = {16'h0000, rword};
    end
    next_state.tx_pulse = 1'b0;
    next_state.rx_pulse = 1'b0;
    if (take & write_in & word_ok) begin
      unique case (index)
        gosc_pkg::IDX_COUNT_LOW: begin
          next_state.count_low = wdata;
        end
        gosc_pkg::IDX_COUNT_HIGH: begin
          next_state.count_high = wdata;
        end
        gosc_pkg::IDX_SYNC_SETUP: begin
          next_state.timer_ssel = wdata[gosc_pkg::POS_TIMER_SSEL +: 3];
          next_state.width = wdata[gosc_pkg::POS_WIDTH +: 8];
        end
        gosc_pkg::IDX_SOURCE_SELECT: begin
          next_state.fifo_ssel = wdata[gosc_pkg::POS_FIFO_SSEL +: 3];
        end
        gosc_pkg::IDX_DRIVE: begin
          next_state.drive = wdata[10:0];
        end
        gosc_pkg::IDX_ONESHOT: begin
          next_state.tx_shot_bit = wdata[gosc_pkg::POS_TX_ONESHOT];
          next_state.rx_shot_bit = wdata[gosc_pkg::POS_RX_ONESHOT];
          // Only a zero-to-one change fires; rewriting a one does nothing.
          next_state.tx_pulse = wdata[gosc_pkg::POS_TX_ONESHOT]
            & ~state.tx_shot_bit;
          next_state.rx_pulse = wdata[gosc_pkg::POS_RX_ONESHOT]
            & ~state.rx_shot_bit;
        end
        gosc_pkg::IDX_MASK_COMPOSITE: begin
          next_state.mask_composite =
            wdata[gosc_pkg::POS_MASK_COMPOSITE +: 4];
        end
        gosc_pkg::IDX_MASK_METERS_A: begin
          next_state.mask_tx_meter =
            wdata[gosc_pkg::POS_MASK_TX_METER +: 12];
          next_state.mask_rx_meter[11:8] =
            wdata[gosc_pkg::POS_MASK_RX_MSB +: 4];
        end
        gosc_pkg::IDX_MASK_METERS_B: begin
          next_state.mask_rx_meter[7:0] =
            wdata[gosc_pkg::POS_MASK_RX_LSB +: 8];
        end
        gosc_pkg::IDX_MASK_CIC: begin
          next_state.mask_cic = wdata[gosc_pkg::POS_MASK_CIC +: 12];
        end
        default: begin
          next_state.ack = 1'b0;
        end
      endcase
    end
    // Interval timer: one step per clock, back to zero at the count.
    next_state.timer = state.timer + 32'h0000_0001;
    if (state.pulse_left != 9'h000) begin
      next_state.pulse_left = state.pulse_left - 9'h001;
    end
    if (restart) begin
      next_state.timer = 32'h0000_0000;
    end else if (reach) begin
      next_state.timer = 32'h0000_0000;
      next_state.pulse_left = {1'b0, state.width} + 9'h001;
    end
    next_state.timer_sync = next_state.pulse_left != 9'h000;
    next_state.fifo_sync = sources[state.fifo_ssel];
    next_state.sources = irq_events_in & masks;
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state <= '0;
      state.count_low <= gosc_pkg::RST_COUNT;
      state.count_high <= gosc_pkg::RST_COUNT;
      state.timer_ssel <= gosc_pkg::RST_TIMER_SSEL;
      state.width <= gosc_pkg::RST_WIDTH;
      state.fifo_ssel <= gosc_pkg::RST_FIFO_SSEL;
      state.drive <= gosc_pkg::RST_DRIVE;
    end else begin
      state <= next_state;
    end
  end

  // Each slice's sync pin has its own enable bit; slice 0's also drives both sync outputs.
  for (genvar s = 0; s < gosc_pkg::SLICES; s++) begin : g_slice
    assign drive_oe_n_out.slice_sync_oe_n[s] =
      state.drive[gosc_pkg::POS_SLICE0 + s];
  end

  assign drive_oe_n_out.tx_sync_out_oe_n = state.drive[4];
  assign drive_oe_n_out.rx_sync_out_oe_n = state.drive[4];
  assign drive_oe_n_out.port_d_oe_n = state.drive[3];
  assign drive_oe_n_out.port_c_oe_n = state.drive[2];
  assign drive_oe_n_out.test_clock_oe_n = state.drive[2];
  assign drive_oe_n_out.test_iq_flag_oe_n = state.drive[2];
  assign drive_oe_n_out.test_sync_oe_n = state.drive[2];
  assign drive_oe_n_out.port_b_oe_n = state.drive[1];
  assign drive_oe_n_out.port_a_oe_n = state.drive[0];
  assign drive_oe_n_out.transmit_iq_flag_oe_n = state.drive[0];
  assign drive_oe_n_out.tx_clock_oe_n = state.drive[0];

  assign readdata_out = state.rdata;
  assign tx_oneshot_out = state.tx_pulse;
  assign rx_oneshot_out = state.rx_pulse;
  assign timer_sync_out = state.timer_sync;
  assign fifo_pointer_reset_out = state.fifo_sync;
  assign irq_sources_out = state.sources;
  assign irq_request_out = |state.sources;

endmodule : gosc_ctrl

// ### test/gosc_ctrl_chk.sv
// Port checker for the control register bank.
// Assumes it is bound to gosc_ctrl and shares its single clock.
module gosc_ctrl_chk (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic reset_in,
  // Bus.
  input wire logic [7:0] address_in,
  input wire logic read_in,
  input wire logic write_in,
  input wire logic [3:0] byteenable_in,
  input wire logic [31:0] writedata_in,
  input wire logic [31:0] readdata_out,
  input wire logic waitrequest_out,
  // Syncs, drives and interrupts.
  input wire logic [7:0] rx_sync_sources_in,
  input wire gosc_pkg::gosc_irq_src_t irq_events_in,
  input wire gosc_pkg::gosc_drive_t drive_oe_n_out,
  input wire logic tx_oneshot_out,
  input wire logic rx_oneshot_out,
  input wire logic timer_sync_out,
  input wire logic fifo_pointer_reset_out,
  input wire gosc_pkg::gosc_irq_src_t irq_sources_out,
  input wire logic irq_request_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (reset_in);
  logic req;
  logic acc;
  gosc_pkg::gosc_drive_t d;
  assign req = read_in || write_in;
  assign acc = write_in && !waitrequest_out && address_in == 8'h90;
  assign d = drive_oe_n_out;
  // A taken write to the drive word must show on the pins a cycle later.
  logic drive_wr;
  assign drive_wr = write_in && !waitrequest_out && address_in == 8'h8c
    && byteenable_in[0];
  wait_first_a: assert property ($rose(req) |-> waitrequest_out)
    else $error("No wait state on a new request.");
  wait_one_a: assert property (req && waitrequest_out |=> !waitrequest_out)
    else $error("More than one wait state.");
  wait_idle_a: assert property (!req |-> !waitrequest_out)
    else $error("Wait request without a request.");
  drive_a_a: assert property (d.port_a_oe_n == d.tx_clock_oe_n &&
    d.port_a_oe_n == d.transmit_iq_flag_oe_n)
    else $error("Port a group enables differ.");
  drive_c_a: assert property (d.port_c_oe_n == d.test_clock_oe_n &&
    d.port_c_oe_n == d.test_sync_oe_n &&
    d.test_iq_flag_oe_n == d.test_sync_oe_n)
    else $error("Port c group enables differ.");
  drive_s0_a: assert property (
    d.slice_sync_oe_n[0] == d.tx_sync_out_oe_n &&
    d.tx_sync_out_oe_n == d.rx_sync_out_oe_n)
    else $error("Slice 0 group enables differ.");
  drive_wr_a: assert property (drive_wr |=>
    d.port_a_oe_n == $past(writedata_in[0]) &&
    d.port_b_oe_n == $past(writedata_in[1]) &&
    d.port_c_oe_n == $past(writedata_in[2]) &&
    d.port_d_oe_n == $past(writedata_in[3]) &&
    d.slice_sync_oe_n == $past(writedata_in[7:4]))
    else $error("Drive enables do not follow the write.");
  tx_shot_a: assert property (tx_oneshot_out |->
    $past(acc && writedata_in[15]))
    else $error("Transmit pulse without a setting write.");
  rx_shot_a: assert property (rx_oneshot_out |->
    $past(acc && writedata_in[7]))
    else $error("Receive pulse without a setting write.");
  shot_once_a: assert property (tx_oneshot_out || rx_oneshot_out |=>
    !tx_oneshot_out && !rx_oneshot_out)
    else $error("One-shot pulse longer than a cycle.");
  irq_or_a: assert property (irq_request_out == |irq_sources_out)
    else $error("Request is not the OR of sources.");
  irq_gate_a: assert property (
    (irq_sources_out & ~$past(irq_events_in)) == 40'h0)
    else $error("Source shown without its event.");
endmodule : gosc_ctrl_chk

// ### test/tb_gosc_ctrl.sv
// Self-checking bench for the control register bank.
// Assumes the block alone, its ports driven straight from here.
module tb_gosc_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [7:0] address_in = 8'h00;
  logic read_in = 1'b0;
  logic write_in = 1'b0;
  logic [31:0] writedata_in = 32'h0000_0000;
  logic [7:0] rx_sync_sources_in = 8'h00;
  gosc_pkg::gosc_irq_src_t irq_events_in = '0;
  logic [31:0] readdata_out;
  logic [31:0] q;
  logic waitrequest_out, tx_oneshot_out, rx_oneshot_out, ts_q;
  logic timer_sync_out, fifo_pointer_reset_out, irq_request_out;
  gosc_pkg::gosc_drive_t drive_oe_n_out;
  gosc_pkg::gosc_irq_src_t irq_sources_out;
  int num_errors = 0, compares = 0, cyc = 0, n_tx = 0, n_rx = 0, n_ff = 0;
  int ts_last = 0, ts_per = 0, ts_hi = 0, ts_w = 0;
  gosc_ctrl gosc_ctrl_i (
    .clk_in(clk_in), .reset_in(reset_in), .address_in(address_in),
    .read_in(read_in), .write_in(write_in), .byteenable_in(4'h3),
    .writedata_in(writedata_in), .readdata_out(readdata_out),
    .waitrequest_out(waitrequest_out),
    .rx_sync_sources_in(rx_sync_sources_in), .irq_events_in(irq_events_in),
    .drive_oe_n_out(drive_oe_n_out), .tx_oneshot_out(tx_oneshot_out),
    .rx_oneshot_out(rx_oneshot_out), .timer_sync_out(timer_sync_out),
    .fifo_pointer_reset_out(fifo_pointer_reset_out),
    .irq_sources_out(irq_sources_out), .irq_request_out(irq_request_out));
  always #2 clk_in = ~clk_in;
  // Pulses are counted here so that no pulse slips between two tasks.
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    ts_q <= timer_sync_out;
    if (tx_oneshot_out === 1'b1) n_tx <= n_tx + 1;
    if (rx_oneshot_out === 1'b1) n_rx <= n_rx + 1;
    if (fifo_pointer_reset_out === 1'b1) n_ff <= n_ff + 1;
    if (timer_sync_out === 1'b1 && ts_q !== 1'b1) begin
      ts_per <= cyc - ts_last;
      ts_last <= cyc;
      ts_hi <= 1;
    end else if (timer_sync_out === 1'b1) ts_hi <= ts_hi + 1;
    if (timer_sync_out === 1'b0 && ts_q === 1'b1) ts_w <= ts_hi;
    if (cyc == 20000) begin
      num_errors++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("Checks %0d, errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict
  task automatic check(input string nm, input logic [39:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  function automatic gosc_pkg::gosc_drive_t exp_drv(input logic [7:0] b);
    return {{3{b[0]}}, b[1], {4{b[2]}}, b[3], b[7:4], b[4], b[4]};
  endfunction : exp_drv
  task automatic bus(input logic we, input logic [7:0] a,
    input logic [15:0] v);
    @(posedge clk_in);
    address_in <= a;
    writedata_in <= {16'h0000, v};
    read_in <= !we;
    write_in <= we;
    do @(posedge clk_in); while (waitrequest_out !== 1'b0);
    q = readdata_out;
    read_in <= 1'b0;
    write_in <= 1'b0;
    @(posedge clk_in);
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    bus(1'b0, a, 16'h0000);
    check("readdata", {8'h00, q}, {24'h00_0000, e});
  endtask : rd
  task automatic t_reset();
    check("drive", 40'(drive_oe_n_out), 40'h7fff);
    rd(8'h14, 16'hffff);
    rd(8'h18, 16'hffff);
    rd(8'h20, 16'h6000);
    rd(8'h8c, 16'h07ff);
    rd(8'ha8, 16'h0000);
    rd(8'h00, 16'h0000);
  endtask : t_reset
  task automatic t_drive();
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, 8'h8c, 16'h07ff ^ (16'h0001 << i));
      check("drive", 40'(drive_oe_n_out),
        40'(exp_drv(~(8'h01 << i))));
    end
    bus(1'b1, 8'h8d, 16'h0000);
    rd(8'h8c, 16'h077f);
  endtask : t_drive
  task automatic t_shot();
    bus(1'b1, 8'h90, 16'h8080);
    bus(1'b1, 8'h90, 16'h8080);
    bus(1'b1, 8'h90, 16'h0000);
    bus(1'b1, 8'h90, 16'h8080);
    repeat (3) @(posedge clk_in);
    check("tx pulses", 40'(n_tx), 40'h2);
    check("rx pulses", 40'(n_rx), 40'h2);
    check("fifo resets", 40'(n_ff), 40'h0);
  endtask : t_shot
  task automatic t_fifo();
    rx_sync_sources_in <= 8'h40;
    @(posedge clk_in);
    rx_sync_sources_in <= 8'h00;
    repeat (3) @(posedge clk_in);
    check("fifo resets", 40'(n_ff), 40'h1);
    bus(1'b1, 8'h20, 16'h1000);
    bus(1'b1, 8'h90, 16'h0000);
    bus(1'b1, 8'h90, 16'h0080);
    rx_sync_sources_in <= 8'h40;
    @(posedge clk_in);
    rx_sync_sources_in <= 8'h00;
    repeat (3) @(posedge clk_in);
    check("fifo resets", 40'(n_ff), 40'h2);
    check("tx pulses", 40'(n_tx), 40'h2);
    check("rx pulses", 40'(n_rx), 40'h3);
  endtask : t_fifo
  // The timer is restarted after the new count is set, as it may already be past it.
  task automatic t_timer();
    bus(1'b1, 8'h14, 16'h0009);
    bus(1'b1, 8'h18, 16'h0000);
    // Four cycles high covers the slowest user of this sync here.
    bus(1'b1, 8'h1c, 16'h0303);
    rx_sync_sources_in <= 8'h08;
    @(posedge clk_in);
    rx_sync_sources_in <= 8'h00;
    repeat (40) @(posedge clk_in);
    check("period", 40'(ts_per), 40'ha);
    check("width", 40'(ts_w), 40'h4);
  endtask : t_timer
  task automatic t_irq();
    bus(1'b1, 8'ha4, 16'h5000);
    bus(1'b1, 8'ha8, 16'habc9);
    bus(1'b1, 8'hac, 16'h3400);
    bus(1'b1, 8'hb0, 16'h0f0f);
    rd(8'hb0, 16'h0f0f);
    irq_events_in <= '1;
    repeat (2) @(posedge clk_in);
    check("sources", irq_sources_out,
      40'h5a_bc93_4f0f);
    check("request", 40'(irq_request_out), 40'h1);
    irq_events_in <= '0;
    repeat (2) @(posedge clk_in);
    check("request", 40'(irq_request_out), 40'h0);
  endtask : t_irq
  initial begin
    repeat (12) @(posedge clk_in);
    reset_in <= 1'b0;
    t_reset();
    t_drive();
    t_shot();
    t_fifo();
    t_timer();
    t_irq();
    give_verdict();
  end
endmodule : tb_gosc_ctrl
bind gosc_ctrl gosc_ctrl_chk gosc_ctrl_chk_i (
  .clk_in(clk_in), .reset_in(reset_in), .address_in(address_in),
  .read_in(read_in), .write_in(write_in), .byteenable_in(byteenable_in),
  .writedata_in(writedata_in), .readdata_out(readdata_out),
  .waitrequest_out(waitrequest_out),
  .rx_sync_sources_in(rx_sync_sources_in), .irq_events_in(irq_events_in),
  .drive_oe_n_out(drive_oe_n_out), .tx_oneshot_out(tx_oneshot_out),
  .rx_oneshot_out(rx_oneshot_out), .timer_sync_out(timer_sync_out),
  .fifo_pointer_reset_out(fifo_pointer_reset_out),
  .irq_sources_out(irq_sources_out), .irq_request_out(irq_request_out));
